// file: scan_timestamp_output_control_test.sv
// Purpose: self-checking bench for the timestamp and output block
// Assumes: short ms prescaler, zero-wait APB slave
// Notes: counter wrap is out of reach in a short run
module scan_timestamp_output_control_test import sto_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CMS = 10;
  localparam int SYC = 100;
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic head_index_pin = 1'b0;
  logic [1:0] dig_in_pin = 2'h0;
  logic sync_out_pin;
  logic [2:0] out_pin;
  logic time_req = 1'b0;
  logic reply_valid;
  logic [31:0] reply_ts;
  logic meas_valid = 1'b0;
  logic stamp_valid;
  logic [31:0] meas_stamp;
  logic [2:0] case_hit = 3'h0;
  logic cont_pt_valid = 1'b0;
  logic cont_pt_in_band = 1'b1;
  logic cont_scan_end = 1'b0;
  logic [31:0] plen;
  logic [31:0] edges;
  logic [31:0] host_ts;
  logic [31:0] rdat;
  logic [31:0] t0;
  logic er;
  int n_errors = 0;
  int checked = 0;

  always #5 sys_clk = ~sys_clk;

  sto_top #(.CYC_PER_MS_P(CMS), .SYNC_CYC_P(SYC)) u_sto_top (
    .sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .head_index_pin(head_index_pin), .dig_in_pin(dig_in_pin),
    .sync_out_pin(sync_out_pin), .out_pin(out_pin),
    .time_req(time_req), .reply_valid(reply_valid),
    .reply_ts(reply_ts), .meas_valid(meas_valid),
    .stamp_valid(stamp_valid), .meas_stamp(meas_stamp),
    .case_hit(case_hit), .cont_pt_valid(cont_pt_valid),
    .cont_pt_in_band(cont_pt_in_band), .cont_scan_end(cont_scan_end));

  sto_host_model #(.CYC_MS(CMS)) u_sto_host_model (
    .sys_clk(sys_clk), .rst_n(rst_n), .sync_out_pin(sync_out_pin),
    .reply_valid(reply_valid), .reply_ts(reply_ts),
    .pulse_len(plen), .edges(edges), .host_ts(host_ts));

  // ==========================================================
  // closing report
  task results;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // apb transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_errors++;
      results();
    end
    rdat = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask

  // settle: let the edge's updates land before sampling
  task wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task sethit(input logic [2:0] v);
    @(posedge sys_clk);
    case_hit <= v;
  endtask

  // one time request together with one measured data set
  task req;
    @(posedge sys_clk);
    time_req <= 1'b1;
    meas_valid <= 1'b1;
    @(posedge sys_clk);
    time_req <= 1'b0;
    meas_valid <= 1'b0;
    #1;
  endtask

  // four-point scan, the third point optionally out of band
  task scan(input logic bad);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      cont_pt_valid <= 1'b1;
      cont_pt_in_band <= !(bad && i == 2);
      cont_scan_end <= (i == 3);
    end
    @(posedge sys_clk);
    cont_pt_valid <= 1'b0;
    cont_scan_end <= 1'b0;
    wt(3);
  endtask

  function automatic logic [31:0] cfg(logic [7:0] m, logic o, logic h,
      logic [1:0] r, logic l, logic [13:0] hold);
    return {2'h0, hold, 3'h0, l, r, h, o, m};
  endfunction

  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    wt(1);
    `CHK(out_pin, 3'h7)
    `CHK(sync_out_pin, 1'b0)
    rdchk(OFS_CTRL, 32'h0);
    rdchk(OFS_OUTCFG, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    `CHK({er, rdat}, 33'h1_0000_0000)
    // two reads exactly 50 cycles apart, so five ticks
    apb(1'b0, OFS_TSTAMP, 32'h0);
    t0 = rdat;
    wt(47);
    rdchk(OFS_TSTAMP, t0 + 32'h5);
    t0 = edges;
    req();
    `CHK({reply_valid, stamp_valid}, 2'h3)
    `CHK(reply_ts, meas_stamp)
    wt(1);
    `CHK(reply_valid, 1'b0)
    rdchk(OFS_REPLY, reply_ts);
    `CHK(edges, t0)
    apb(1'b1, OFS_CTRL, 32'h1);
    req();
    `CHK(sync_out_pin, 1'b1)
    t0 = reply_ts;
    wt(SYC + 5);
    `CHK(plen, 32'(SYC))
    `CHK(host_ts, t0 + 32'hA)
    // index edges 40 cycles apart; first edge only arms the period,
    // so pulses of 1, 1 and then half a period follow
    apb(1'b1, OFS_CTRL, 32'h2);
    t0 = edges;
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      head_index_pin <= 1'b1;
      repeat (2) @(posedge sys_clk);
      head_index_pin <= 1'b0;
      repeat (37) @(posedge sys_clk);
    end
    wt(5);
    `CHK(plen, 32'h14)
    `CHK(edges, t0 + 32'h3)
    rdchk(OFS_PERIOD, 32'h28);
    apb(1'b1, OFS_CTRL, 32'h0);
    // both link operators over cases one and two
    for (int op = 0; op < 2; op++) begin
      apb(1'b1, OFS_OUTCFG, cfg(8'h06, op[0], 1'b0, 2'h0, 1'b0, 14'h0));
      sethit(3'h1);
      wt(3);
      `CHK(out_pin[0], !op[0])
      sethit(3'h3);
      wt(3);
      `CHK(out_pin[0], 1'b0)
      sethit(3'h0);
      wt(2);
      `CHK(out_pin[0], 1'b1)
    end
    apb(1'b1, OFS_OUTCFG, cfg(8'h06, 1'b1, 1'b1, 2'h0, 1'b0, 14'h0));
    wt(2);
    `CHK(out_pin[0], 1'b0)
    sethit(3'h2);
    wt(3);
    `CHK(out_pin[0], 1'b1)
    // delayed release after 3 ms, between 20 and 30 cycles
    apb(1'b1, OFS_OUTCFG, cfg(8'h06, 1'b1, 1'b0, 2'h1, 1'b0, 14'h3));
    sethit(3'h0);
    wt(15);
    `CHK(out_pin[0], 1'b0)
    wt(20);
    `CHK(out_pin[0], 1'b1)
    // release only when input 0 reaches high
    apb(1'b1, OFS_OUTCFG, cfg(8'h06, 1'b1, 1'b0, 2'h2, 1'b1, 14'h0));
    sethit(3'h1);
    wt(3);
    sethit(3'h0);
    wt(30);
    `CHK(out_pin[0], 1'b0)
    @(posedge sys_clk);
    dig_in_pin <= 2'h1;
    wt(5);
    `CHK(out_pin[0], 1'b1)
    // contour case drives output 1
    apb(1'b1, OFS_OUTCFG + 8'h04,
        cfg(8'h01, 1'b1, 1'b0, 2'h0, 1'b0, 14'h0));
    scan(1'b0);
    `CHK(out_pin[1], 1'b1)
    scan(1'b1);
    `CHK(out_pin[1], 1'b0)
    rdchk(OFS_STATUS, 32'h0002_0002);
    scan(1'b0);
    `CHK(out_pin[1], 1'b1)
    results();
  end
endmodule

// file: sto_host_model.sv
// Purpose: far-side controller watching the sync pin and time replies
// Assumes: outputs sampled on sys_clk rising edges
// Notes: observation only; it never drives the device
module sto_host_model #(
  parameter int CYC_MS = 10
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // device outputs watched
  input wire logic sync_out_pin,
  input wire logic reply_valid,
  input wire logic [31:0] reply_ts,
  // observations
  output logic [31:0] pulse_len,
  output logic [31:0] edges,
  output logic [31:0] host_ts
);
  logic prev_q;
  logic [31:0] run_q;
  logic [31:0] since_q;
  logic [31:0] rts_q;

  // ==========================================================
  // host time: replied stamp plus whole ms since the edge
  assign host_ts = rts_q + since_q / CYC_MS;

  // pulse measurement; edge found on the first high sample, length in samples
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
      run_q <= 32'h0;
      since_q <= 32'h0;
      rts_q <= 32'h0;
      pulse_len <= 32'h0;
      edges <= 32'h0;
    end else begin
      prev_q <= sync_out_pin;
      since_q <= since_q + 32'h1;
      if (sync_out_pin && !prev_q) begin // leading edge
        edges <= edges + 32'h1;
        run_q <= 32'h1;
        since_q <= 32'h0;
      end else if (sync_out_pin) begin
        run_q <= run_q + 32'h1;
      end
      if (!sync_out_pin && prev_q) begin
        pulse_len <= run_q;
      end
      if (reply_valid) begin
        rts_q <= reply_ts;
      end
    end
  end
endmodule

// file: sto_out_chan.sv
// Purpose: one switching output with case linking, polarity and reset mode
// Assumes: case_hit, ms_tick and dig_in already in the sys_clk domain
// Notes: rmode 3 behaves as immediate reset
module sto_out_chan import sto_pkg::*; #(
  parameter int NUM_CASE = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // evaluation results and timing
  input wire logic [NUM_CASE-1:0] case_hit,
  input wire logic ms_tick,
  input wire logic dig_in,
  // configuration
  input wire logic [NUM_CASE-1:0] case_mask,
  input wire logic op_or,
  input wire logic active_high,
  input wire logic [1:0] rmode,
  input wire logic in_level,
  input wire logic [HOLD_W-1:0] hold_ms,
  // output
  output logic out_pin,
  output logic out_active
);

  typedef enum logic [3:0] {
    CH_IDLE = 4'b0001,
    CH_ACTIVE = 4'b0010,
    CH_HOLD = 4'b0100,
    CH_WAIT = 4'b1000
  } sto_ch_type;

  typedef struct packed {
    sto_ch_type st;
    logic [HOLD_W-1:0] cnt;
    logic pin;
  } sto_chan_type;

  sto_chan_type q, d;
  logic cond;
  logic [HOLD_W-1:0] hold_lim;

  // ==========================================================
  // linking of the selected cases; no case selected never fires
  always_comb begin
    if (case_mask == '0) begin
      cond = 1'b0;
    end else if (op_or) begin
      cond = |(case_hit & case_mask);
    end else begin
      cond = &(case_hit | ~case_mask);
    end
  end

  // longer settings are clipped to the longest hold-off
  assign hold_lim = (hold_ms > HOLD_W'(HOLD_MAX_MS)) ?
                    HOLD_W'(HOLD_MAX_MS) : hold_ms;

  // ==========================================================
  // output state machine
  always_comb begin
    d = q;
    case (q.st)
      CH_IDLE: begin
        if (cond) begin
          d.st = CH_ACTIVE;
        end
      end
      CH_ACTIVE: begin
        if (!cond) begin
          if (rmode == RST_DELAY && hold_lim != '0) begin
            d.st = CH_HOLD;
            d.cnt = hold_lim;
          end else if (rmode == RST_INPUT) begin
            d.st = CH_WAIT;
          end else begin
            d.st = CH_IDLE;
          end
        end
      end
      CH_HOLD: begin
        // a returning condition cancels the hold-off
        if (cond) begin
          d.st = CH_ACTIVE;
        end else if (ms_tick) begin
          if (q.cnt == HOLD_W'(1)) begin
            d.st = CH_IDLE;
          end else begin
            d.cnt = q.cnt - HOLD_W'(1);
          end
        end
      end
      CH_WAIT: begin
        if (dig_in == in_level) begin
          d.st = cond ? CH_ACTIVE : CH_IDLE;
        end
      end
      default: begin
        d.st = CH_IDLE;
      end
    endcase
    // xnor: active level is high only when configured so
    d.pin = (d.st != CH_IDLE) ~^ active_high;
  end

  // state register; pin idles high as the default is active low
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q.st <= CH_IDLE;
      q.cnt <= '0;
      q.pin <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign out_pin = q.pin;
  assign out_active = (q.st != CH_IDLE);

  // ==========================================================
  // checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_link_or;
    op_or && |(case_hit & case_mask) |=> out_active;
  endproperty
  a_link_or: assert property (p_link_or)
    else $error("or-linked case did not raise output");

  property p_link_and;
    !op_or && case_mask != '0 && &(case_hit | ~case_mask) |=> out_active;
  endproperty
  a_link_and: assert property (p_link_and)
    else $error("and-linked cases did not raise output");

  property p_polarity;
    $stable(active_high) |-> out_pin == (active_high ? out_active :
                                          !out_active);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("output pin level disagrees with polarity");

  property p_immediate;
    q.st == CH_ACTIVE && !cond && rmode == RST_IMMEDIATE |=> !out_active;
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("output not released at once");

  property p_hold;
    q.st == CH_HOLD && !ms_tick |=> out_active;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold-off ended without a tick");

  property p_wait_in;
    q.st == CH_WAIT && dig_in != in_level |=> out_active;
  endproperty
  a_wait_in: assert property (p_wait_in)
    else $error("output released before input level");

endmodule

// file: sto_pkg.sv
// Purpose: shared constants and types for the timestamp and output block
// Assumes: sys_clk at 100 MHz, registers reached over APB
// Notes: register offsets are byte addresses, one 32-bit word each
package sto_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000000;
  localparam int CYC_PER_MS = TICK_NS / CLK_PERIOD_NS;
  localparam int SYNC_PULSE_MS = 10;
  localparam int SYNC_PULSE_CYC = SYNC_PULSE_MS * CYC_PER_MS;
  localparam int HOLD_MAX_MS = 10000;
  localparam int TS_W = 32;
  localparam int HOLD_W = 14;

  // ==========================================================
  // register offsets and reset values
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TSTAMP = 8'h04;
  localparam logic [7:0] OFS_REPLY = 8'h08;
  localparam logic [7:0] OFS_PERIOD = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_OUTCFG = 8'h20;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [31:0] OUTCFG_RST = 32'h00000000;

  // ==========================================================
  // field positions
  localparam int CTRL_METH_LSB = 0;
  localparam int CFG_MASK_LSB = 0;
  localparam int CFG_OR_BIT = 8;
  localparam int CFG_HIGH_BIT = 9;
  localparam int CFG_RMODE_LSB = 10;
  localparam int CFG_INLVL_BIT = 12;
  localparam int CFG_INSEL_LSB = 13;
  localparam int CFG_HOLD_LSB = 16;
  localparam int ST_OUT_LSB = 0;
  localparam int ST_SYNC_BIT = 16;
  localparam int ST_CONT_BIT = 17;

  // ==========================================================
  // modes
  typedef enum logic [1:0] {
    METH_TELEGRAM = 2'h0,
    METH_TIMER_READ = 2'h1,
    METH_INDEX = 2'h2
  } sto_meth_type;

  typedef enum logic [1:0] {
    RST_IMMEDIATE = 2'h0,
    RST_DELAY = 2'h1,
    RST_INPUT = 2'h2
  } sto_rmode_type;

endpackage

// file: sto_top.sv
// Purpose: millisecond timestamp, sync pulse output and switching outputs
// Assumes: telegram, contour and evaluation inputs on sys_clk; pins async
// Notes: APB answers with zero wait states, unmapped reads set pslverr
module sto_top import sto_pkg::*; #(
  parameter int NUM_OUT = 3,
  parameter int NUM_IN = 2,
  parameter int NUM_CASE = 4,
  parameter int CYC_PER_MS_P = CYC_PER_MS,
  parameter int SYNC_CYC_P = SYNC_PULSE_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device pins
  input wire logic head_index_pin,
  input wire logic [NUM_IN-1:0] dig_in_pin,
  output logic sync_out_pin,
  output logic [NUM_OUT-1:0] out_pin,
  // telegram side
  input wire logic time_req,
  output logic reply_valid,
  output logic [TS_W-1:0] reply_ts,
  // measured contour data
  input wire logic meas_valid,
  output logic stamp_valid,
  output logic [TS_W-1:0] meas_stamp,
  // field evaluation
  input wire logic [NUM_CASE-2:0] case_hit,
  input wire logic cont_pt_valid,
  input wire logic cont_pt_in_band,
  input wire logic cont_scan_end
);

  // ==========================================================
  // state
  typedef enum logic [1:0] {
    SY_IDLE = 2'b01,
    SY_PULSE = 2'b10
  } sto_sy_type;

  typedef struct packed {
    logic [TS_W-1:0] ts;
    logic [31:0] pre;
    logic tick;
    sto_sy_type sy;
    logic [31:0] cnt;
    logic [31:0] len;
    logic sync;
    logic [31:0] per_cnt;
    logic [31:0] period;
    logic per_ok;
    logic [TS_W-1:0] reply;
    logic reply_v;
    logic [TS_W-1:0] stamp;
    logic stamp_v;
    logic [1:0] meth;
    logic [NUM_OUT-1:0][31:0] cfg;
    logic idx_s1;
    logic idx_s2;
    logic idx_s3;
    logic [NUM_IN-1:0] din_s1;
    logic [NUM_IN-1:0] din_s2;
    logic cont_run;
    logic cont_viol;
    logic [31:0] rdata;
    logic err;
  } sto_state_type;

  sto_state_type q, d;
  logic [NUM_CASE-1:0] cases;
  logic [NUM_OUT-1:0] chan_active;
  logic idx_rise;
  logic [31:0] half;
  logic trig_tr;
  logic trig_ix;
  logic bad_pt;

  // ==========================================================
  // helpers
  // byte offset to output channel, NUM_OUT when not a channel
  function automatic int chan_of(input logic [7:0] a);
    int r;
    r = NUM_OUT;
    for (int i = 0; i < NUM_OUT; i++) begin
      if (a == OFS_OUTCFG + 8'(4 * i)) begin
        r = i;
      end
    end
    return r;
  endfunction

  // selected input; a select past the last input reads low
  function automatic logic in_pick(input logic [NUM_IN-1:0] v,
                                   input logic [1:0] s);
    logic r;
    r = 1'b0;
    for (int k = 0; k < NUM_IN; k++) begin
      if (s == 2'(k)) begin
        r = v[k];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // sync and trigger terms
  assign idx_rise = q.idx_s2 & ~q.idx_s3;
  // half a revolution, never below one cycle
  assign half = ((q.period >> 1) == '0) ? 32'h1 : (q.period >> 1);
  assign trig_tr = time_req && q.meth == METH_TIMER_READ;
  assign trig_ix = idx_rise && q.meth == METH_INDEX;
  assign bad_pt = cont_pt_valid & ~cont_pt_in_band;
  // case 0 is the contour field, the rest come from evaluation
  assign cases = {case_hit, q.cont_viol};

  // ==========================================================
  // next state
  always_comb begin
    int ch;
    ch = chan_of(paddr);
    d = q;

    // millisecond prescaler
    d.tick = 1'b0;
    if (q.pre == 32'(CYC_PER_MS_P - 1)) begin
      d.pre = '0;
      d.tick = 1'b1;
    end else begin
      d.pre = q.pre + 32'h1;
    end

    // timestamp wraps naturally at all ones
    if (q.tick) begin
      d.ts = q.ts + 32'h1;
    end

    // stamp each measured data set
    d.stamp_v = meas_valid;
    if (meas_valid) begin
      d.stamp = q.ts;
    end

    // reply one cycle after the request, far inside the 3 ms bound
    d.reply_v = time_req;
    if (time_req) begin
      d.reply = q.ts;
    end

    // index pin synchroniser; edge taken past the second stage
    d.idx_s1 = head_index_pin;
    d.idx_s2 = q.idx_s1;
    d.idx_s3 = q.idx_s2;
    d.din_s1 = dig_in_pin;
    d.din_s2 = q.din_s1;

    // revolution period in cycles; the counter saturates when the head stops, and a period loaded from it then wraps to zero;
    // the first edge only arms it, time since reset is no period
    if (idx_rise) begin
      if (q.per_ok) begin
        d.period = q.per_cnt + 32'h1;
      end
      d.per_ok = 1'b1;
      d.per_cnt = '0;
    end else if (q.per_cnt != '1) begin
      d.per_cnt = q.per_cnt + 32'h1;
    end

    // sync pulse; a new trigger restarts the pulse
    case (q.sy)
      SY_IDLE: begin
        if (trig_tr) begin
          d.sy = SY_PULSE;
          d.len = 32'(SYNC_CYC_P);
          d.cnt = 32'(SYNC_CYC_P);
        end else if (trig_ix) begin
          d.sy = SY_PULSE;
          d.len = half;
          d.cnt = half;
        end
      end
      SY_PULSE: begin
        if (trig_tr) begin
          d.len = 32'(SYNC_CYC_P);
          d.cnt = 32'(SYNC_CYC_P);
        end else if (trig_ix) begin
          d.len = half;
          d.cnt = half;
        end else if (q.cnt == 32'h1) begin
          d.sy = SY_IDLE;
        end else begin
          d.cnt = q.cnt - 32'h1;
        end
      end
      default: begin
        d.sy = SY_IDLE;
      end
    endcase
    d.sync = (d.sy == SY_PULSE);

    // contour band check; points on the end cycle still count
    if (cont_scan_end) begin
      d.cont_viol = q.cont_run | bad_pt;
      d.cont_run = 1'b0;
    end else if (bad_pt) begin
      d.cont_run = 1'b1;
    end

    // apb read data prepared in the setup cycle
    if (psel && !penable) begin
      d.err = 1'b0;
      d.rdata = '0;
      if (paddr == OFS_CTRL) begin
        d.rdata[CTRL_METH_LSB +: 2] = q.meth;
      end else if (paddr == OFS_TSTAMP) begin
        d.rdata = q.ts;
      end else if (paddr == OFS_REPLY) begin
        d.rdata = q.reply;
      end else if (paddr == OFS_PERIOD) begin
        d.rdata = q.period;
      end else if (paddr == OFS_STATUS) begin
        d.rdata[ST_OUT_LSB +: NUM_OUT] = chan_active;
        d.rdata[ST_SYNC_BIT] = q.sync;
        d.rdata[ST_CONT_BIT] = q.cont_viol;
      end else if (ch < NUM_OUT) begin
        d.rdata = q.cfg[ch];
      end else begin
        d.err = 1'b1;
      end
    end

    // apb write at the access edge; read-only words ignore it
    if (psel && penable && pwrite && !q.err) begin
      if (paddr == OFS_CTRL) begin
        d.meth = pwdata[CTRL_METH_LSB +: 2];
      end else if (ch < NUM_OUT) begin
        d.cfg[ch] = pwdata;
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q <= '0;
      q.sy <= SY_IDLE;
      q.meth <= CTRL_RST;
      q.cfg <= {NUM_OUT{OUTCFG_RST}};
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // switching outputs
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_chan
    logic sel_in;
    assign sel_in = in_pick(q.din_s2, q.cfg[i][CFG_INSEL_LSB +: 2]);
    sto_out_chan #(
      .NUM_CASE(NUM_CASE)
    ) u_chan (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .case_hit(cases),
      .ms_tick(q.tick),
      .dig_in(sel_in),
      .case_mask(q.cfg[i][CFG_MASK_LSB +: NUM_CASE]),
      .op_or(q.cfg[i][CFG_OR_BIT]),
      .active_high(q.cfg[i][CFG_HIGH_BIT]),
      .rmode(q.cfg[i][CFG_RMODE_LSB +: 2]),
      .in_level(q.cfg[i][CFG_INLVL_BIT]),
      .hold_ms(q.cfg[i][CFG_HOLD_LSB +: HOLD_W]),
      .out_pin(out_pin[i]),
      .out_active(chan_active[i])
    );
  end

  // ==========================================================
  // outputs
  assign prdata = q.rdata;
  assign pready = 1'b1; // zero wait states keep the master simple
  assign pslverr = psel & penable & q.err;
  assign sync_out_pin = q.sync;
  assign reply_valid = q.reply_v;
  assign reply_ts = q.reply;
  assign stamp_valid = q.stamp_v;
  assign meas_stamp = q.stamp;

  // ==========================================================
  // checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_tick_rate;
    q.pre == 32'(CYC_PER_MS_P - 1) |=> q.tick && q.pre == '0;
  endproperty
  a_tick_rate: assert property (p_tick_rate)
    else $error("millisecond tick missing at prescaler end");

  property p_ts_step;
    q.tick |=> q.ts == $past(q.ts) + 32'h1;
  endproperty
  a_ts_step: assert property (p_ts_step)
    else $error("timestamp did not step by one");

  property p_ts_wrap;
    q.tick && q.ts == '1 |=> q.ts == '0;
  endproperty
  a_ts_wrap: assert property (p_ts_wrap)
    else $error("timestamp did not wrap to zero");

  property p_stamp;
    meas_valid |=> stamp_valid && meas_stamp == $past(q.ts);
  endproperty
  a_stamp: assert property (p_stamp)
    else $error("measured data stamped wrongly");

  sequence s_request;
    time_req;
  endsequence

  sequence s_reply;
    reply_valid && reply_ts == $past(q.ts);
  endsequence

  property p_reply;
    s_request |=> s_reply;
  endproperty
  a_reply: assert property (p_reply)
    else $error("time reply missing or wrong");

  property p_sync_start;
    s_request and trig_tr |=> s_reply and sync_out_pin &&
                              q.len == 32'(SYNC_CYC_P);
  endproperty
  a_sync_start: assert property (p_sync_start)
    else $error("sync pulse not started with stamped reply");

  property p_sync_hold;
    q.sy == SY_PULSE && q.cnt > 32'h1 |=> sync_out_pin;
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("sync pulse ended early");

  property p_index_len;
    trig_ix |=> sync_out_pin && q.len ==
      (($past(q.period) >> 1) == '0 ? 32'h1 : $past(q.period) >> 1);
  endproperty
  a_index_len: assert property (p_index_len)
    else $error("index pulse missing or wrong length");

  property p_contour;
    cont_scan_end && (q.cont_run || bad_pt) |=> q.cont_viol;
  endproperty
  a_contour: assert property (p_contour)
    else $error("contour violation not flagged");

endmodule
